/* addressing_and_load_pkg.sv */
/*
 * Constants, encodings and state codes shared by the load and addressing
 * decoder. Assumes one cpu clock and an external memory that answers a
 * read combinationally from the registered address.
 */
// Operation
// - indexed displacement is byte after opcode
// - signed displacement, index register left unchanged
// - opcode bit fields pick source and destination
// - implied arithmetic writes the accumulator for every operation except ALU_CP, which leaves it unwritten
// - register pair contents address the operand
// - 16-bit operand: low at pointer, high plus one
// - three opcode bits select bit; three modes
// - fetch opcode, decode, perform the transfer
// - opcode 48H copies B into C
// - opcode 72 stores D at primary pointer
// - instructions one to four bytes; alu single
// - prefix byte forms two-byte opcodes
// - indexed loads three bytes, displacement third
// - extended: opcode, low, high; 3A loads A
// - immediate register load: opcode then literal
package addressing_and_load_pkg;

   localparam logic [7:0]  OP_PFX_X    = 8'hDD;
   localparam logic [7:0]  OP_PFX_Y    = 8'hFD;
   localparam logic [7:0]  OP_PFX_BIT  = 8'hCB;
   localparam logic [7:0]  OP_HALT     = 8'h76;
   localparam logic [7:0]  OP_LD_A_BC  = 8'h0A;
   localparam logic [7:0]  OP_LD_A_DE  = 8'h1A;
   localparam logic [7:0]  OP_ST_BC    = 8'h02;
   localparam logic [7:0]  OP_ST_DE    = 8'h12;
   localparam logic [7:0]  OP_LD_A_EXT = 8'h3A;
   localparam logic [7:0]  OP_ST_EXT   = 8'h32;

   localparam logic [2:0]  REG_MEM     = 3'h6;
   localparam logic [2:0]  REG_A       = 3'h7;
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [15:0] SP_RESET    = 16'hFFFF;
   localparam logic [7:0]  REG_RESET   = 8'h00;

   localparam logic [1:0]  IDX_NONE    = 2'h0;
   localparam logic [1:0]  IDX_X       = 2'h1;
   localparam logic [1:0]  IDX_Y       = 2'h2;

   localparam logic [1:0]  PTR_HL      = 2'h0;
   localparam logic [1:0]  PTR_BC      = 2'h1;
   localparam logic [1:0]  PTR_DE      = 2'h2;
   localparam logic [1:0]  PTR_NN      = 2'h3;

   localparam logic [1:0]  CB_ROT      = 2'h0;
   localparam logic [1:0]  CB_BIT      = 2'h1;
   localparam logic [1:0]  CB_SET      = 2'h3;

   localparam logic [2:0]  ALU_ADD     = 3'h0;
   localparam logic [2:0]  ALU_ADC     = 3'h1;
   localparam logic [2:0]  ALU_SUB     = 3'h2;
   localparam logic [2:0]  ALU_SBC     = 3'h3;
   localparam logic [2:0]  ALU_AND     = 3'h4;
   localparam logic [2:0]  ALU_XOR     = 3'h5;
   localparam logic [2:0]  ALU_OR      = 3'h6;
   localparam logic [2:0]  ALU_CP      = 3'h7;

   // step bits of an instruction, in the order they are carried out
   localparam int          STEP_MRD    = 5;
   localparam int          STEP_MWR    = 6;

   typedef enum logic [9:0] {
      ST_DISP  = 10'h001,
      ST_CBOP  = 10'h002,
      ST_IMM   = 10'h004,
      ST_NLO   = 10'h008,
      ST_NHI   = 10'h010,
      ST_MRD   = 10'h020,
      ST_MWR   = 10'h040,
      ST_POPLO = 10'h080,
      ST_POPHI = 10'h100,
      ST_FETCH = 10'h200
   } state_t;

   typedef enum logic [1:0] {
      K_NONE = 2'h0,
      K_MOVE = 2'h1,
      K_ALU  = 2'h2,
      K_CB   = 2'h3
   } kind_t;

endpackage

/* addressing_and_load_decoder.sv */
/*
 * Fetches and executes the 8-bit load group, register-source arithmetic,
 * bit set/reset/test and pops, with register, implied, register indirect,
 * indexed, immediate and extended addressing.
 * Assumes memory returns mem_rdata in the same cycle as mem_rd, from the
 * registered mem_addr, and takes a write at the edge that ends mem_wr.
 */
`timescale 1ns/1ps
`default_nettype none
module addressing_and_load_decoder
   import addressing_and_load_pkg::*;
(
   input  wire logic        clk,                // cpu clock
   input  wire logic        rst,                // synchronous reset
   output logic [15:0]      mem_addr,           // memory address
   output logic             mem_rd,             // read strobe
   output logic             mem_wr,             // write strobe
   output logic [7:0]       mem_wdata,          // write data
   input  wire logic [7:0]  mem_rdata,          // read data
   output logic             opcode_fetch_cycle, // opcode byte on the bus
   output logic [7:0]       acc,                // accumulator
   output logic             flag_zero,          // zero flag
   output logic             flag_carry          // carry flag
);

   state_t      state_ff,  nxt_state;
   logic [15:0] pc_ff,     nxt_pc;
   logic [15:0] sp_ff,     nxt_sp;
   logic [15:0] ix_ff,     nxt_ix;
   logic [15:0] iy_ff,     nxt_iy;
   logic [1:0]  idx_ff,    nxt_idx;
   kind_t       kind_ff,   nxt_kind;
   logic [2:0]  dst_ff,    nxt_dst;
   logic [2:0]  src_ff,    nxt_src;
   logic [1:0]  ptr_ff,    nxt_ptr;
   logic [1:0]  cbf_ff,    nxt_cbf;
   logic [2:0]  bit_ff,    nxt_bit;
   logic [7:0]  disp_ff,   nxt_disp;
   logic [7:0]  nlo_ff,    nxt_nlo;
   logic [8:0]  pend_ff,   pend;
   logic [15:0] addr_ff,   nxt_addr;
   logic        rd_ff,     nxt_rd;
   logic        wr_ff,     nxt_wr;
   logic [7:0]  wdata_ff,  nxt_wdata;
   logic        m1_ff,     nxt_m1;
   logic        zero_ff,   nxt_zero;
   logic        carry_ff,  nxt_carry;
   logic [7:0]  rf_ff [0:7];

   logic [8:0]  rem;
   logic        exec;
   logic [7:0]  val;
   logic        rf_we;
   logic [2:0]  rf_sel;
   logic [7:0]  rf_val;
   logic [15:0] base;
   logic [15:0] ea;

   // opcode decode of the byte on the bus during a fetch
   wire [7:0] op        = mem_rdata;
   wire       has_idx   = (idx_ff != IDX_NONE);
   wire       is_prefix = (op == OP_PFX_X) || (op == OP_PFX_Y);
   wire       is_move   = (op[7:6] == 2'b01) && (op != OP_HALT);
   wire       is_limm   = (op[7:6] == 2'b00) && (op[2:0] == REG_MEM);
   wire       is_alu    = (op[7:6] == 2'b10);
   wire       is_pop    = (op[7:6] == 2'b11) && (op[3:0] == 4'h1)
                          && (op[5:4] != 2'b11);
   wire       is_cb     = (op == OP_PFX_BIT);
   wire       is_ldind  = (op == OP_LD_A_BC) || (op == OP_LD_A_DE);
   wire       is_stind  = (op == OP_ST_BC) || (op == OP_ST_DE);
   wire       is_ldext  = (op == OP_LD_A_EXT);
   wire       is_stext  = (op == OP_ST_EXT);
   wire       is_ext    = is_ldext || is_stext;
   wire       src_mem   = (op[2:0] == REG_MEM);
   wire       dst_mem   = (op[5:3] == REG_MEM);
   wire       dec_mrd   = ((is_move || is_alu) && src_mem) || is_ldind
                          || is_ldext;
   wire       dec_mwr   = ((is_move || is_limm) && dst_mem) || is_stind
                          || is_stext;
   wire       dec_disp  = has_idx && (((is_move || is_alu) && src_mem)
                          || ((is_move || is_limm) && dst_mem) || is_cb);
   // steps still to run, one bit per byte or access
   wire [8:0] pend_dec  = {is_pop, is_pop, dec_mwr, dec_mrd, is_ext,
                           is_ext, is_limm, is_cb, dec_disp};
   wire       cb_mem    = has_idx || (mem_rdata[2:0] == REG_MEM);

   // arithmetic and bit results
   wire       cin       = ((nxt_dst == ALU_ADC) || (nxt_dst == ALU_SBC))
                          && carry_ff;
   wire [8:0] alu_sum   = {1'b0, rf_ff[REG_A]} + {1'b0, val} + {8'h00, cin};
   wire [8:0] alu_dif   = {1'b0, rf_ff[REG_A]} - {1'b0, val} - {8'h00, cin};
   wire [7:0] cb_mask   = 8'h01 << nxt_bit;
   wire [7:0] cb_res    = nxt_cbf[0] ? (val | cb_mask) : (val & ~cb_mask);
   logic [8:0] alu_res;

   always_comb begin
      unique case (nxt_dst)
         ALU_ADD, ALU_ADC: alu_res = alu_sum;
         ALU_AND:          alu_res = {1'b0, rf_ff[REG_A] & val};
         ALU_XOR:          alu_res = {1'b0, rf_ff[REG_A] ^ val};
         ALU_OR:           alu_res = {1'b0, rf_ff[REG_A] | val};
         default:          alu_res = alu_dif;
      endcase
   end

   always_comb begin
      nxt_pc   = pc_ff;
      nxt_sp   = sp_ff;
      nxt_ix   = ix_ff;
      nxt_iy   = iy_ff;
      nxt_idx  = idx_ff;
      nxt_kind = kind_ff;
      nxt_dst  = dst_ff;
      nxt_src  = src_ff;
      nxt_ptr  = ptr_ff;
      nxt_cbf  = cbf_ff;
      nxt_bit  = bit_ff;
      nxt_disp = disp_ff;
      nxt_nlo  = nlo_ff;
      pend     = pend_ff;
      exec     = 1'b0;
      val      = mem_rdata;
      rf_we    = 1'b0;
      rf_sel   = dst_ff;
      rf_val   = mem_rdata;
      unique case (state_ff)
         ST_FETCH: begin
            nxt_pc = pc_ff + 16'h0001;
            if (is_prefix) begin
               nxt_idx = (op == OP_PFX_Y) ? IDX_Y : IDX_X;
               pend    = 9'h000;
            end else begin
               pend     = pend_dec;
               nxt_dst  = (is_ldind || is_ldext) ? REG_A : op[5:3];
               nxt_src  = (is_stind || is_stext) ? REG_A : op[2:0];
               nxt_ptr  = is_ext ? PTR_NN :
                          (is_ldind || is_stind) ? (op[4] ? PTR_DE : PTR_BC)
                          : PTR_HL;
               nxt_kind = is_alu ? K_ALU : is_cb ? K_CB :
                          (is_move || is_limm || is_ldind || is_ldext)
                          ? K_MOVE : K_NONE;
               exec     = (pend_dec == 9'h000);
               val      = rf_ff[nxt_src];
            end
         end
         ST_DISP: begin
            nxt_pc   = pc_ff + 16'h0001;
            nxt_disp = mem_rdata;
         end
         ST_CBOP: begin
            nxt_pc  = pc_ff + 16'h0001;
            nxt_cbf = mem_rdata[7:6];
            nxt_bit = mem_rdata[5:3];
            nxt_dst = mem_rdata[2:0];
            pend[STEP_MRD] = cb_mem && (nxt_cbf != CB_ROT);
            pend[STEP_MWR] = cb_mem && nxt_cbf[1];
            exec = !cb_mem;
            val  = rf_ff[nxt_dst];
         end
         ST_IMM: begin
            nxt_pc = pc_ff + 16'h0001;
            exec   = !pend_ff[STEP_MWR];
         end
         ST_NLO: begin
            nxt_pc  = pc_ff + 16'h0001;
            nxt_nlo = mem_rdata;
         end
         ST_NHI:  nxt_pc = pc_ff + 16'h0001;
         ST_MRD:  exec = 1'b1;
         ST_MWR:  exec = 1'b0;
         ST_POPLO, ST_POPHI: begin
            rf_sel = {dst_ff[2:1], state_ff == ST_POPLO};
            if (has_idx && (dst_ff[2:1] == 2'b10)) begin
               if (idx_ff == IDX_X) begin
                  nxt_ix = (state_ff == ST_POPLO) ? {ix_ff[15:8], val}
                                                  : {val, ix_ff[7:0]};
               end else begin
                  nxt_iy = (state_ff == ST_POPLO) ? {iy_ff[15:8], val}
                                                  : {val, iy_ff[7:0]};
               end
            end else begin
               rf_we = 1'b1;
            end
            if (state_ff == ST_POPHI) begin
               nxt_sp = sp_ff + 16'h0002;
            end
         end
         default: pend = 9'h000;
      endcase
      if (exec) begin
         unique case (nxt_kind)
            K_MOVE: begin
               rf_we  = 1'b1;
               rf_sel = nxt_dst;
               rf_val = val;
            end
            K_ALU: begin
               rf_we  = (nxt_dst != ALU_CP);
               rf_sel = REG_A;
               rf_val = alu_res[7:0];
            end
            K_CB: begin
               rf_we  = (state_ff == ST_CBOP) && nxt_cbf[1];
               rf_sel = nxt_dst;
               rf_val = cb_res;
            end
            default: rf_we = 1'b0;
         endcase
      end
   end

   // flags follow arithmetic and bit tests only
   always_comb begin
      nxt_zero  = zero_ff;
      nxt_carry = carry_ff;
      if (exec && (nxt_kind == K_ALU)) begin
         nxt_zero  = (alu_res[7:0] == 8'h00);
         nxt_carry = (nxt_dst < ALU_AND) ? alu_res[8] : 1'b0;
      end else if (exec && (nxt_kind == K_CB) && (nxt_cbf == CB_BIT)) begin
         nxt_zero  = ~val[nxt_bit];
      end
   end

   // effective address: pair, extended word or index plus displacement
   always_comb begin
      unique case (nxt_ptr)
         PTR_BC:  base = {rf_ff[0], rf_ff[1]};
         PTR_DE:  base = {rf_ff[2], rf_ff[3]};
         PTR_NN:  base = {mem_rdata, nlo_ff};
         default: base = {rf_ff[4], rf_ff[5]};
      endcase
      if (idx_ff == IDX_X) begin
         ea = ix_ff + {{8{nxt_disp[7]}}, nxt_disp};
      end else if (idx_ff == IDX_Y) begin
         ea = iy_ff + {{8{nxt_disp[7]}}, nxt_disp};
      end else begin
         ea = base;
      end
   end

   // next step is the lowest pending one; none left means next opcode
   assign rem       = pend & ~state_ff[8:0];
   assign nxt_state = (rem == 9'h000) ? ST_FETCH
                      : state_t'({1'b0, rem & (~rem + 9'h001)});
   assign nxt_rd    = (nxt_state != ST_MWR);
   assign nxt_wr    = (nxt_state == ST_MWR);
   assign nxt_m1    = (nxt_state == ST_FETCH);
   assign nxt_addr  = ((nxt_state == ST_MRD) || (nxt_state == ST_MWR)) ? ea
                      : (nxt_state == ST_POPLO) ? sp_ff
                      : (nxt_state == ST_POPHI) ? sp_ff + 16'h0001
                      : nxt_pc;
   assign nxt_wdata = (state_ff == ST_MRD) ? cb_res
                      : (state_ff == ST_IMM) ? mem_rdata
                      : rf_ff[nxt_src];

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= ST_FETCH;
         pc_ff    <= PC_RESET;
         sp_ff    <= SP_RESET;
         ix_ff    <= 16'h0000;
         iy_ff    <= 16'h0000;
         idx_ff   <= IDX_NONE;
         kind_ff  <= K_NONE;
         dst_ff   <= 3'h0;
         src_ff   <= 3'h0;
         ptr_ff   <= PTR_HL;
         cbf_ff   <= CB_ROT;
         bit_ff   <= 3'h0;
         disp_ff  <= 8'h00;
         nlo_ff   <= 8'h00;
         pend_ff  <= 9'h000;
         addr_ff  <= PC_RESET;
         rd_ff    <= 1'b1;
         wr_ff    <= 1'b0;
         wdata_ff <= 8'h00;
         m1_ff    <= 1'b1;
         zero_ff  <= 1'b0;
         carry_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pc_ff    <= nxt_pc;
         sp_ff    <= nxt_sp;
         ix_ff    <= nxt_ix;
         iy_ff    <= nxt_iy;
         idx_ff   <= (nxt_m1 && (state_ff != ST_FETCH || !is_prefix))
                     ? IDX_NONE : nxt_idx;
         kind_ff  <= nxt_kind;
         dst_ff   <= nxt_dst;
         src_ff   <= nxt_src;
         ptr_ff   <= nxt_ptr;
         cbf_ff   <= nxt_cbf;
         bit_ff   <= nxt_bit;
         disp_ff  <= nxt_disp;
         nlo_ff   <= nxt_nlo;
         pend_ff  <= rem;
         addr_ff  <= nxt_addr;
         rd_ff    <= nxt_rd;
         wr_ff    <= nxt_wr;
         wdata_ff <= nxt_wdata;
         m1_ff    <= nxt_m1;
         zero_ff  <= nxt_zero;
         carry_ff <= nxt_carry;
      end
   end

   for (genvar g = 0; g < 8; g++) begin : g_rf
      always_ff @(posedge clk) begin
         if (rst) begin
            rf_ff[g] <= REG_RESET;
         end else if (rf_we && (rf_sel == 3'(g))) begin
            rf_ff[g] <= rf_val;
         end
      end
   end

   assign mem_addr           = addr_ff;
   assign mem_rd             = rd_ff;
   assign mem_wr             = wr_ff;
   assign mem_wdata          = wdata_ff;
   assign opcode_fetch_cycle = m1_ff;
   assign acc                = rf_ff[REG_A];
   assign flag_zero          = zero_ff;
   assign flag_carry         = carry_ff;

endmodule
`default_nettype wire

/* decoder_properties.sv */
/*
 * Concurrent checks on the ports of the load and addressing decoder.
 * Assumes zero-wait asynchronous memory and the package's opcode values.
 */
`timescale 1ns/1ps
`default_nettype none
module decoder_properties
   import addressing_and_load_pkg::*;
(
   input wire logic        clk,                // cpu clock
   input wire logic        rst,                // synchronous reset
   input wire logic [15:0] mem_addr,           // memory address
   input wire logic        mem_rd,             // read strobe
   input wire logic        mem_wr,             // write strobe
   input wire logic [7:0]  mem_wdata,          // write data
   input wire logic [7:0]  mem_rdata,          // read data
   input wire logic        opcode_fetch_cycle, // opcode byte on the bus
   input wire logic [7:0]  acc,                // accumulator
   input wire logic        flag_zero,          // zero flag
   input wire logic        flag_carry          // carry flag
);
   logic pfx_ff;
   logic nxt_pfx;

   // previous fetch was an index prefix byte
   assign nxt_pfx = opcode_fetch_cycle
                    && (mem_rdata == OP_PFX_X || mem_rdata == OP_PFX_Y);

   always_ff @(posedge clk) begin
      if (rst) begin
         pfx_ff <= 1'b0;
      end else begin
         pfx_ff <= nxt_pfx;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RESET_FETCH: assert property (
      $fell(rst) |-> opcode_fetch_cycle && mem_rd && mem_addr == PC_RESET)
      else $error("no opcode fetch at the reset address");
   AST_ONE_STROBE: assert property (
      mem_rd != mem_wr)
      else $error("read and write strobes not exclusive");
   AST_WR_THEN_FETCH: assert property (
      mem_wr |=> opcode_fetch_cycle && mem_rd)
      else $error("write not followed by a fetch");
   AST_MOVE_ONE: assert property (
      opcode_fetch_cycle && mem_rdata[7:6] == 2'h1 && mem_rdata[2:0] != REG_MEM
      && mem_rdata[5:3] != REG_MEM
      |=> opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001)
      else $error("register move not one byte");
   AST_STORE_PTR: assert property (
      opcode_fetch_cycle && !pfx_ff && mem_rdata == 8'h72
      |=> mem_wr && !opcode_fetch_cycle
      ##1 opcode_fetch_cycle && mem_addr == $past(mem_addr, 2) + 16'h0001)
      else $error("store through pointer pair malformed");
   AST_EXT_ADDR: assert property (
      opcode_fetch_cycle && !pfx_ff && mem_rdata == OP_LD_A_EXT
      |=> mem_addr == $past(mem_addr) + 16'h0001
      ##1 mem_addr == $past(mem_addr) + 16'h0001
      ##1 mem_rd && mem_addr == {$past(mem_rdata), $past(mem_rdata, 2)}
      ##1 opcode_fetch_cycle)
      else $error("extended address order wrong");
   AST_IDX_LEN: assert property (
      pfx_ff && opcode_fetch_cycle && mem_rdata[7:6] == 2'h1
      && mem_rdata[2:0] == REG_MEM && mem_rdata != OP_HALT
      |=> !opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001
      ##1 mem_rd && !opcode_fetch_cycle
      ##1 opcode_fetch_cycle && mem_addr == $past(mem_addr, 2) + 16'h0001)
      else $error("indexed load not three bytes");
   AST_IMM_LEN: assert property (
      opcode_fetch_cycle && mem_rdata[7:6] == 2'h0 && mem_rdata[2:0] == 3'h6
      && mem_rdata[5:3] != REG_MEM
      |=> !opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001
      ##1 opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001)
      else $error("immediate load not two bytes");
   AST_ALU_ONE: assert property (
      opcode_fetch_cycle && mem_rdata[7:6] == 2'h2 && mem_rdata[2:0] != REG_MEM
      |=> opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001)
      else $error("register arithmetic not one byte");
   AST_POP_PAIR: assert property (
      opcode_fetch_cycle && (mem_rdata == 8'hC1 || mem_rdata == 8'hD1
      || mem_rdata == 8'hE1)
      |=> !opcode_fetch_cycle
      ##1 !opcode_fetch_cycle && mem_addr == $past(mem_addr) + 16'h0001)
      else $error("pair high byte not at pointer plus one");
endmodule

bind addressing_and_load_decoder decoder_properties u_props (
   .clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
   .opcode_fetch_cycle(opcode_fetch_cycle), .acc(acc),
   .flag_zero(flag_zero), .flag_carry(flag_carry));
`default_nettype wire

/* memory_model.sv */
/*
 * Zero-wait program and data memory of 64K bytes.
 * Assumes the bench preloads ram directly; reads are combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module memory_model (
   input wire logic        clk,       // cpu clock
   input wire logic [15:0] mem_addr,  // address
   input wire logic        mem_rd,    // read strobe
   input wire logic        mem_wr,    // write strobe
   input wire logic [7:0]  mem_wdata, // write data
   output logic [7:0]      mem_rdata  // read data
);
   logic [7:0] ram [0:65535];
   logic [7:0] last_ff;

   always @(posedge clk) begin
      if (mem_wr)
         ram[mem_addr] <= mem_wdata;
      if (mem_rd)
         last_ff <= ram[mem_addr];
   end

   // data bus not held outside a read: show inverse of last byte
   assign mem_rdata = mem_rd ? ram[mem_addr] : ~last_ff;
endmodule
`default_nettype wire

/* testbench.sv */
/*
 * Self-checking bench: each test loads a program, resets, runs to the
 * fetch after its last byte and checks memory, accumulator or flags.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import addressing_and_load_pkg::*;
   logic        clk;
   logic        rst;
   logic [15:0] mem_addr;
   logic        mem_rd;
   logic        mem_wr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic        opcode_fetch_cycle;
   logic [7:0]  acc;
   logic        flag_zero;
   logic        flag_carry;
   int          num_errors;
   int          compares;
   logic [7:0]  prog [$];

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   memory_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   addressing_and_load_decoder dut (.clk(clk), .rst(rst),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .opcode_fetch_cycle(opcode_fetch_cycle), .acc(acc),
      .flag_zero(flag_zero), .flag_carry(flag_carry));

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // clear memory, hold reset, then place prog at 0000
   task automatic load();
      int i;
      for (i = 0; i < 65536; i++)
         mem.ram[i] = 8'h00;
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      for (i = 0; i < prog.size(); i++)
         mem.ram[i] = prog[i];
   endtask

   // release reset and run to the fetch just past the program
   task automatic run();
      int n;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      for (n = 0; n < 300; n++) begin
         @(negedge clk);
         if (opcode_fetch_cycle === 1'b1 && mem_addr === 16'(prog.size()))
            break;
      end
      if (n == 300) begin
         num_errors++;
         $display("wrong value program end expected fetch seen timeout");
         wrap_up();
      end
   endtask

   task automatic t_move_store();
      prog = '{8'h26, 8'h80, 8'h2E, 8'h10, 8'h06, 8'h5A, 8'h48, 8'h51, 8'h72};
      load();
      run();
      check("via ptr", mem.ram[16'h8010], 8'h5A);
      $display("test move_store done");
   endtask

   task automatic t_extended();
      prog = '{8'h3A, 8'h32, 8'h6F, 8'h32, 8'h00, 8'h90};
      load();
      mem.ram[16'h6F32] = 8'hA5;
      run();
      check("extended load", acc, 8'hA5);
      check("extended store", mem.ram[16'h9000], 8'hA5);
      $display("test extended done");
   endtask

   task automatic t_indexed();
      prog = '{8'hDD, 8'h7E, 8'hF8, 8'hFD, 8'h77, 8'h7F,
               8'hDD, 8'h36, 8'h80, 8'h99, 8'hDD, 8'h7E, 8'h81};
      load();
      mem.ram[16'hFFF8] = 8'h3C;
      mem.ram[16'hFF81] = 8'hC3;
      run();
      check("second index store", mem.ram[16'h007F], 8'h3C);
      check("indexed immediate", mem.ram[16'hFF80], 8'h99);
      check("index unchanged", acc, 8'hC3);
      $display("test indexed done");
   endtask

   task automatic t_alu();
      prog = '{8'h3E, 8'h0F, 8'h06, 8'hF1, 8'h80};
      load();
      run();
      check("sum in accumulator", acc, 8'h00);
      check("zero flag", {7'h00, flag_zero}, 8'h01);
      check("carry flag", {7'h00, flag_carry}, 8'h01);
      $display("test alu done");
   endtask

   task automatic t_bit();
      int b;
      prog = {};
      for (b = 0; b < 8; b++) begin
         prog.push_back(OP_PFX_BIT);
         prog.push_back({2'h3, 3'(b), 3'h7});
      end
      prog = {prog, 8'hCB, 8'h87, 8'hCB, 8'h47, 8'h26, 8'h90, 8'h2E, 8'h00,
              8'hCB, 8'hDE, 8'hDD, 8'hCB, 8'h7F, 8'hE6};
      load();
      run();
      check("bits set then reset", acc, 8'hFE);
      check("bit test", {7'h00, flag_zero}, 8'h01);
      check("bit via pointer", mem.ram[16'h9000], 8'h08);
      check("bit via index", mem.ram[16'h007F], 8'h10);
      $display("test bit done");
   endtask

   task automatic t_pop();
      prog = '{8'h26, 8'hA0, 8'h2E, 8'h00, 8'hD1, 8'h73, 8'h2E, 8'h01, 8'h72};
      load();
      mem.ram[16'hFFFF] = 8'h4B;
      run();
      check("pair low byte", mem.ram[16'hA000], 8'h4B);
      check("pair high byte", mem.ram[16'hA001], 8'h26);
      $display("test pop done");
   endtask

   initial begin
      rst = 1'b1;
      num_errors = 0;
      compares = 0;
      t_move_store();
      t_extended();
      t_indexed();
      t_alu();
      t_bit();
      t_pop();
      wrap_up();
   end
endmodule
`default_nettype wire
